// *** logic/scivr_pkg.sv ***
// constants for the slot control initial value register block
`default_nettype none
package scivr_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NFIELD = 9;
   // register byte addresses
   localparam logic [11:0] INIT_VALUE_ADDR = 12'h420;
   localparam logic [11:0] STATUS_ADDR = 12'h424;
   // field positions inside slot_control_initial_value
   localparam int BUTTON_PRESS_EVENT_EN_POS = 0;
   localparam int POWER_FAULT_EVENT_EN_POS = 1;
   localparam int LATCH_SENSOR_CHANGE_EN_POS = 2;
   localparam int PRESENCE_CHANGE_EN_POS = 3;
   localparam int CMD_DONE_IRQ_EN_POS = 4;
   localparam int HOTPLUG_IRQ_EN_POS = 5;
   localparam int ATTENTION_LAMP_CTL_POS = 6;
   localparam int POWER_LAMP_CTL_POS = 8;
   localparam int SLOT_POWER_SWITCH_CTL_POS = 10;
   localparam int LINK_ACTIVE_CHANGE_EN_POS = 12;
   // per-field lsb and width, field index order as above
   localparam int FIELD_LSB [NFIELD] = '{0, 1, 2, 3, 4, 5, 6, 8, 10};
   localparam int FIELD_WID [NFIELD] = '{1, 1, 1, 1, 1, 1, 2, 2, 1};
   localparam int LINK_FIELD = 9;
   // reset values
   localparam logic [15:0] ATTENTION_LAMP_CTL_RST = 16'h00c0;
   localparam logic [15:0] POWER_LAMP_CTL_RST = 16'h0100;
   localparam logic [15:0] INIT_VALUE_RST = ATTENTION_LAMP_CTL_RST | POWER_LAMP_CTL_RST;
   localparam logic [15:0] INIT_VALUE_MASK = 16'h17ff;
   // status register layout
   localparam int STAT_CAP_EN_POS = 0;
   localparam int STAT_PART_RST_POS = 1;
   localparam int STAT_LOAD_CNT_LSB = 8;
   localparam int LOAD_CNT_W = 8;
   // ahb constants
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic HRESP_OKAY = 1'h0;
endpackage
`default_nettype wire

// *** logic/scivr_reg_if.sv ***
// register access carrier between bus slave and register bank
`timescale 1ns/10ps
`default_nettype none
interface scivr_reg_if;
   logic wrStb;
   logic [11:0] wrAddr;
   logic [31:0] wrData;
   logic [11:0] rdAddr;
   logic [31:0] rdData;
   modport bus (output wrStb, output wrAddr, output wrData, output rdAddr, input rdData);
   modport regs (input wrStb, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface
`default_nettype wire

// *** logic/scivr_ahb_slave.sv ***
// zero wait state ahb-lite slave front end
`timescale 1ns/10ps
`default_nettype none
module scivr_ahb_slave (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // register side
   scivr_reg_if.bus regIf
);
   typedef struct packed {
      logic wrPend;
      logic [11:0] wrAddr;
      logic [31:0] rdData;
   } scivr_ahb_st_t;

   scivr_ahb_st_t st_r;
   scivr_ahb_st_t st_nxt;
   logic addrPhase;

   // hsize is not decoded: only whole-word transfers are issued
   assign addrPhase = hsel && hready && (htrans[1] != 1'b0);

   assign regIf.rdAddr = {haddr[11:2], 2'h0};
   assign regIf.wrStb = st_r.wrPend;
   assign regIf.wrAddr = st_r.wrAddr;
   assign regIf.wrData = hwdata;

   always_comb begin
      st_nxt = st_r;
      st_nxt.wrPend = addrPhase && hwrite;
      if (addrPhase) begin
         st_nxt.wrAddr = {haddr[11:2], 2'h0};
      end
      // read data captured at the address phase so it comes from a flop
      if (addrPhase && !hwrite) begin
         st_nxt.rdData = regIf.rdData;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = scivr_pkg::HRESP_OKAY;
   assign hrdata = st_r.rdData;
endmodule
`default_nettype wire

// *** logic/scivr_top.sv ***
// slot control initial value register bank with load paths to slot control
// Operation
// RULE1: capability enable rising loads every slot control field from initial values.
// RULE2: software write to initial values updates slot control fields at once.
// RULE3: partition reset leaves the write-lockable capability bits untouched.
// RULE4: after partition fundamental reset, slot control fields take programmed initial values.
// RULE5: bits 0-3 hold the four event enables, each resetting to zero.
// RULE6: bit 4 command-complete irq enable, bit 5 hot-plug irq enable, reset zero.
// RULE7: bits 7:6 attention lamp reset 3, 9:8 power lamp reset 1, bit 10 zero.
// RULE8: bit 12 link active change enable, reset zero, immediate write effect too.
// RULE9: fields survive partition resets; only full fundamental reset restores defaults.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module scivr_top #(
   parameter int NFIELD = scivr_pkg::NFIELD
) (
   // clock and full fundamental reset
   input wire logic clk,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // port state
   input wire logic capEn,
   input wire logic partRstN,
   // load path to slot_control_live
   output logic [NFIELD:0] fieldLoad,
   output logic [15:0] fieldValue
);
   typedef struct packed {
      logic [15:0] initVal;
      logic capEnPrev;
      logic loadPend;
      logic [NFIELD:0] load;
      logic [scivr_pkg::LOAD_CNT_W-1:0] loadCnt;
   } scivr_top_st_t;

   scivr_top_st_t st_r;
   scivr_top_st_t st_nxt;
   scivr_reg_if regIf();
   logic initWr;
   logic loadAll;
   logic [NFIELD:0] fieldMaskHit;

   // reads the register at a byte address, bypassing a write in flight
   function automatic logic [31:0] readReg(input logic [11:0] addr, input logic [15:0] iv,
                                           input logic ce, input logic pr,
                                           input logic [7:0] cnt);
      logic [31:0] v;
      v = 32'h0;
      if (addr == scivr_pkg::INIT_VALUE_ADDR) begin
         v[15:0] = iv & scivr_pkg::INIT_VALUE_MASK;
      end else if (addr == scivr_pkg::STATUS_ADDR) begin
         v[scivr_pkg::STAT_CAP_EN_POS] = ce;
         v[scivr_pkg::STAT_PART_RST_POS] = pr;
         v[scivr_pkg::STAT_LOAD_CNT_LSB +: scivr_pkg::LOAD_CNT_W] = cnt;
      end
      return v;
   endfunction

   scivr_ahb_slave scivr_ahb_slave_inst (
      .clk(clk),
      .nrst(nrst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .regIf(regIf.bus)
   );

   assign initWr = regIf.wrStb && (regIf.wrAddr == scivr_pkg::INIT_VALUE_ADDR);

   // write in the data phase beats the old value for a read right behind it
   always_comb begin
      if (initWr && (regIf.rdAddr == scivr_pkg::INIT_VALUE_ADDR)) begin
         regIf.rdData = readReg(regIf.rdAddr, regIf.wrData[15:0], capEn, !partRstN,
                                st_r.loadCnt);
      end else begin
         regIf.rdData = readReg(regIf.rdAddr, st_r.initVal, capEn, !partRstN, st_r.loadCnt);
      end
   end

   // every field is refreshed by any of the three causes
   assign loadAll = initWr // [RULE2] [RULE8]
      || (capEn && !st_r.capEnPrev) // [RULE1]
      || (st_r.loadPend && partRstN); // [RULE4]

   // one load strobe per field, field LINK_FIELD is the link active enable
   generate
      for (genvar i = 0; i <= NFIELD; i++) begin : gField
         assign fieldMaskHit[i] = loadAll;
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      st_nxt.capEnPrev = capEn;
      st_nxt.load = fieldMaskHit;
      // partition reset only arms a reload; initial values are kept
      if (!partRstN) begin
         st_nxt.loadPend = 1'b1; // [RULE3] [RULE9]
      end else if (loadAll) begin
         st_nxt.loadPend = 1'b0;
      end
      if (initWr) begin
         // reserved bits 11 and 13-15 stay zero
         st_nxt.initVal = regIf.wrData[15:0] & scivr_pkg::INIT_VALUE_MASK; // [RULE2] [RULE8]
      end
      if (loadAll) begin
         st_nxt.loadCnt = st_r.loadCnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         // full reset: defaults restored and a load armed for release
         st_r <= '0;
         st_r.initVal <= scivr_pkg::INIT_VALUE_RST; // [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
         st_r.loadPend <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // value and strobe leave together so the live register sees the new value
   assign fieldLoad = st_r.load;
   assign fieldValue = st_r.initVal;
endmodule
`default_nettype wire

// *** test/scivr_properties.sv ***
// port checker for the slot control initial value block
`timescale 1ns/10ps
`default_nettype none
module scivr_checker #(parameter int NFIELD = 9) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // port state and load path
   input wire logic capEn,
   input wire logic partRstN,
   input wire logic [NFIELD:0] fieldLoad,
   input wire logic [15:0] fieldValue
);
   logic hit, wrA, rdA;
   assign hit = hsel && hready && htrans[1] && haddr[11:2] == scivr_pkg::INIT_VALUE_ADDR[11:2];
   assign wrA = hit && hwrite;
   assign rdA = hit && !hwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wr_load_a: assert property (wrA ##1 partRstN |=> &fieldLoad)
      else $error("no load after write");
   wr_value_a: assert property (wrA |=> ##1
      fieldValue == ($past(hwdata[15:0]) & scivr_pkg::INIT_VALUE_MASK))
      else $error("written value not passed on");
   cap_load_a: assert property ($rose(capEn) && partRstN |=> &fieldLoad)
      else $error("no load on capability enable");
   part_rel_a: assert property ($rose(partRstN) |=> &fieldLoad)
      else $error("no load after partition reset");
   part_quiet_a: assert property (!partRstN && !$rose(capEn) && !$past(wrA)
      |=> fieldLoad == '0)
      else $error("load during partition reset");
   part_keep_a: assert property (!partRstN [*2] |-> $stable(fieldValue))
      else $error("value lost in partition reset");
   rd_data_a: assert property (rdA |=> hrdata == {16'h0000, fieldValue})
      else $error("read data differs from value");
   load_group_a: assert property (fieldLoad == '0 || &fieldLoad)
      else $error("fields loaded apart");
   rsvd_zero_a: assert property ((fieldValue & 16'he800) == 16'h0000)
      else $error("reserved bit set");
   cover property (wrA);
   cover property ($rose(capEn));
   cover property ($rose(partRstN));
endmodule
bind scivr_top scivr_checker #(.NFIELD(NFIELD)) scivr_checker_inst (.clk, .nrst, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .capEn, .partRstN, .fieldLoad,
   .fieldValue);
`default_nettype wire

// *** test/scivr_bench.sv ***
// self-checking bench for the slot control initial value block
`timescale 1ns/10ps
`default_nettype none
module scivr_bench;
   logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic capEn = 1'b0, partRstN = 1'b1, hreadyout, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rs = 32'hb111, v, r;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [9:0] fieldLoad;
   logic [15:0] fieldValue;
   int n_fail = 0, checks_done = 0, nLoad = 0, k;
   scivr_top scivr_top_inst (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .capEn, .partRstN, .fieldLoad,
      .fieldValue);
   always #50 clk = ~clk;
   always @(posedge clk) if (&fieldLoad) nLoad <= nLoad + 1;
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function automatic logic [31:0] iv(input logic [31:0] x);
      return x & 32'h000017ff;
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic ck(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // holds each phase until hready is seen high
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      wt(3);
      nrst <= 1'b1;
      wt(2);
      bus(1'b0, 32'h420, 32'h0);
      ck("reset value", r, 32'h1c0);
      for (int i = 0; i < 24; i++) begin
         v = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : xs();
         bus(1'b1, 32'h420, v);
         bus(1'b0, 32'h420, 32'h0);
         ck("read back", r, iv(v));
         ck("live value", {16'h0000, fieldValue}, iv(v));
      end
      // status and unmapped words must not touch the value
      bus(1'b1, 32'h424, xs());
      bus(1'b1, 32'h5fc, xs());
      bus(1'b0, 32'h5fc, 32'h0);
      ck("unmapped read", r, 32'h0);
      ck("okay response", {31'h0, hresp}, {31'h0, scivr_pkg::HRESP_OKAY});
      bus(1'b0, 32'h420, 32'h0);
      ck("ignored write", r, iv(v));
      k = nLoad;
      capEn <= 1'b1;
      wt(3);
      ck("cap load", nLoad, k + 1);
      bus(1'b0, 32'h424, 32'h0);
      ck("status word", r, (nLoad << 8) | 32'h1);
      bus(1'b1, 32'h420, 32'h155a);
      partRstN <= 1'b0;
      wt(2);
      bus(1'b0, 32'h424, 32'h0);
      ck("partition status", r & 32'h3, 32'h3);
      ck("partition hold", {16'h0000, fieldValue}, 32'h155a);
      k = nLoad;
      partRstN <= 1'b1;
      wt(3);
      ck("partition reload", nLoad, k + 1);
      bus(1'b0, 32'h420, 32'h0);
      ck("after partition", r, 32'h155a);
      nrst <= 1'b0;
      wt(3);
      nrst <= 1'b1;
      wt(2);
      bus(1'b0, 32'h420, 32'h0);
      ck("full reset", r, 32'h1c0);
      print_verdict();
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
endmodule
`default_nettype wire
